// *** verilog/pscs_pkg.sv ***
// package for the power-save clock and short chip select block
// assumes a single 250 MHz clock and a plain register port
// How it works
// - status bits 7:6 read 01 after a watchdog time-out, 11 after reset, else 00, never 10.
// - a read of the global control register clears the status bits to 00 unless a watchdog time-out comes in the same cycle.
// - writing 1 to bit 5 forces a periodic interrupt pending; 0 does nothing; reads zero.
// - field 1:0 disables periodic interrupts at 00, else gives priority 1, 2 or 3.
// - field 4:2 is the clock select code driving cpu clock, peripheral clock, oscillator.
// - 000 is osc/8 both, 001 cpu osc/8 periph osc, 010 full rate, 011 osc/2 both.
// - 110 is osc/4, 111 osc/6, 100 and 101 run from 32 kHz, 101 stops the oscillator.
// - short chip selects apply in every mode but 010; 100 and 101 add self-timed.
// - bits 1:0 of the chip select control register enable short read and write selects.
// - a short read chip select is active only in the last part of the read cycle.
// - wait states between the first and second bus state do not lengthen it.
// - in divided modes a short read select lasts two fast clock cycles.
// - in 32 kHz modes a short read select lasts one 32 kHz cycle.
// - a short write select is active only around the write strobe trailing edge.
// - in divided modes it spans two fast cycles before to two after that edge.
// - in 32 kHz modes it spans one 32 kHz cycle before to one after that edge.
package pscs_pkg;
   localparam logic [3:0] ADDR_GCS      = 4'h0;
   localparam logic [3:0] ADDR_CSCTL    = 4'h1;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
   localparam logic [3:0] ADDR_EVENT    = 4'h4;
   localparam int STAT_HI = 7;
   localparam int STAT_LO = 6;
   localparam int FORCE_BIT = 5;
   localparam int CSEL_HI = 4;
   localparam int CSEL_LO = 2;
   localparam int PRIO_HI = 1;
   localparam int PRIO_LO = 0;
   localparam int SHORT_RD_BIT = 0;
   localparam int SHORT_WR_BIT = 1;
   localparam int SELF_TIMED_BIT = 2;
   localparam logic [1:0] STAT_NONE  = 2'h0;
   localparam logic [1:0] STAT_WDOG  = 2'h1;
   localparam logic [1:0] STAT_RESET = 2'h3;
   localparam logic [2:0] CSEL_RESET = 3'h0;
   localparam logic [1:0] PRIO_RESET = 2'h0;
   localparam logic [2:0] CSCTL_RESET = 3'h0;
   localparam logic [2:0] CS_DIV8  = 3'h0;
   localparam logic [2:0] CS_MIXED = 3'h1;
   localparam logic [2:0] CS_FULL  = 3'h2;
   localparam logic [2:0] CS_DIV2  = 3'h3;
   localparam logic [2:0] CS_32K   = 3'h4;
   localparam logic [2:0] CS_32KOFF = 3'h5;
   localparam logic [2:0] CS_DIV4  = 3'h6;
   localparam logic [2:0] CS_DIV6  = 3'h7;
   localparam int SHORT_FAST_CYC = 2;
   localparam int SHORT_SLOW_CYC = 1;
   localparam int IRQ_W = 4;
   localparam int IRQ_WDOG = 0;
   localparam int IRQ_FORCE = 1;
   localparam int IRQ_CSRD = 2;
   localparam int IRQ_CSWR = 3;
   localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
endpackage

// *** verilog/pscs_div.sv ***
// programmable enable divider: one-cycle tick every ratio input edges
// assumes the input enable comes from the same clock
`timescale 1ns/100ps
module pscs_div
#(
   parameter int W = 4
)
(
   input  wire logic         clock_in,
   input  wire logic         sys_rst_in,
   input  wire logic         en_in,
   input  wire logic [W-1:0] ratio_in,
   output logic              tick_out
);
   logic [W-1:0] count;
   wire          wrap = (count >= ratio_in - W'(1));

   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         count    <= '0;
         tick_out <= 1'b0;
      end
      else
      begin
         tick_out <= en_in & wrap;
         if (en_in)
            count <= wrap ? '0 : count + W'(1);
      end
   end
endmodule

// *** verilog/pscs_top.sv ***
// global control/status register, clock select and short chip selects
// assumes bus state inputs and the 32 kHz tick come from pins
// and the watchdog time-out is a same-clock pulse
`timescale 1ns/100ps
module pscs_top
   import pscs_pkg::*;
(
   input  wire logic       clock_in,
   input  wire logic       sys_rst_in,
   input  wire logic [3:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   output logic [7:0]      rdata_out,
   input  wire logic       wdog_timeout_in,
   input  wire logic       clk32k_in,
   input  wire logic       cycle_active_in,
   input  wire logic       cycle_write_in,
   input  wire logic       state_second_in,
   input  wire logic       wr_strobe_in,
   output logic            chip_sel_out,
   output logic            cpu_clk_en_out,
   output logic            per_clk_en_out,
   output logic            osc_on_out,
   output logic            self_timed_out,
   output logic [1:0]      periodic_prio_out,
   output logic            periodic_force_out,
   output logic            irq_out
);
   import pscs_pkg::*;

   // ==========================================================
   // pin synchronisers
   // ==========================================================
   logic [4:0] sync_a;
   logic [4:0] sync_b;
   logic       k32_prev;
   logic       wrs_prev;
   always_ff @(posedge clock_in)
   begin
      sync_a <= {wr_strobe_in, state_second_in, cycle_write_in,
                 cycle_active_in, clk32k_in};
      sync_b <= sync_a;
   end
   wire k32   = sync_b[0];
   wire cyc   = sync_b[1];
   wire cyc_w = sync_b[2];
   wire st2   = sync_b[3];
   wire wrs   = sync_b[4];
   always_ff @(posedge clock_in)
   begin
      k32_prev <= k32;
      wrs_prev <= wrs;
   end
   wire k32_tick = k32 & ~k32_prev;
   wire wrs_fall = wrs_prev & ~wrs;

   // ==========================================================
   // registers
   // ==========================================================
   logic [1:0]       stat;
   logic [2:0]       csel;
   logic [1:0]       prio;
   logic [2:0]       csctl;
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_mask;
   logic             force_p;

   wire wr_gcs   = wr_in & (addr_in == ADDR_GCS);
   wire rd_gcs   = rd_in & (addr_in == ADDR_GCS);
   wire wr_csctl = wr_in & (addr_in == ADDR_CSCTL);
   wire wr_istat = wr_in & (addr_in == ADDR_IRQ_STAT);
   wire wr_imask = wr_in & (addr_in == ADDR_IRQ_MASK);
   wire force_wr = wr_gcs & wdata_in[FORCE_BIT];
   logic cs_rd_done;
   logic cs_wr_done;
   wire [IRQ_W-1:0] ev = {cs_wr_done, cs_rd_done, force_wr,
                          wdog_timeout_in};
   wire [IRQ_W-1:0] clr = wr_istat ? wdata_in[IRQ_W-1:0] : '0;

   // status: reset reads 11, watchdog 01, a read clears, never 10
   wire [1:0] next_stat = wdog_timeout_in ? (stat | STAT_WDOG)
                        : rd_gcs ? STAT_NONE : stat;

   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         stat     <= STAT_RESET;
         csel     <= CSEL_RESET;
         prio     <= PRIO_RESET;
         csctl    <= CSCTL_RESET;
         irq_stat <= '0;
         irq_mask <= IRQ_MASK_RESET;
         force_p  <= 1'b0;
      end
      else
      begin
         stat    <= next_stat;
         force_p <= force_wr;
         if (wr_gcs)
         begin
            csel <= wdata_in[CSEL_HI:CSEL_LO];
            prio <= wdata_in[PRIO_HI:PRIO_LO];
         end
         if (wr_csctl)
            csctl <= wdata_in[2:0];
         if (wr_imask)
            irq_mask <= wdata_in[IRQ_W-1:0];
         irq_stat <= (irq_stat & ~clr) | ev;
      end
   end

   // ==========================================================
   // read port
   // ==========================================================
   logic [7:0] rmux;
   always_comb
   begin
      unique case (addr_in)
         ADDR_GCS:      rmux = {stat, 1'b0, csel, prio};
         ADDR_CSCTL:    rmux = {5'h00, csctl};
         ADDR_IRQ_STAT: rmux = {4'h0, irq_stat};
         ADDR_IRQ_MASK: rmux = {4'h0, irq_mask};
         default:       rmux = 8'h00;
      endcase
   end
   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
         rdata_out <= 8'h00;
      else
         rdata_out <= rd_in ? rmux : 8'h00;
   end

   // ==========================================================
   // clock select decode
   // ==========================================================
   logic [3:0] cpu_ratio;
   logic [3:0] per_ratio;
   always_comb
   begin
      unique case (csel)
         CS_DIV8:   begin cpu_ratio = 4'h8; per_ratio = 4'h8; end
         CS_MIXED:  begin cpu_ratio = 4'h8; per_ratio = 4'h1; end
         CS_FULL:   begin cpu_ratio = 4'h1; per_ratio = 4'h1; end
         CS_DIV2:   begin cpu_ratio = 4'h2; per_ratio = 4'h2; end
         CS_DIV4:   begin cpu_ratio = 4'h4; per_ratio = 4'h4; end
         CS_DIV6:   begin cpu_ratio = 4'h6; per_ratio = 4'h6; end
         default:   begin cpu_ratio = 4'h1; per_ratio = 4'h1; end
      endcase
   end
   wire slow   = (csel == CS_32K) | (csel == CS_32KOFF);
   wire src_en = slow ? k32_tick : 1'b1;
   logic cpu_tick;
   logic per_tick;

   pscs_div #(.W(4)) u_cpu_div
   (
      .clock_in   (clock_in),
      .sys_rst_in (sys_rst_in),
      .en_in      (src_en),
      .ratio_in   (cpu_ratio),
      .tick_out   (cpu_tick)
   );
   pscs_div #(.W(4)) u_per_div
   (
      .clock_in   (clock_in),
      .sys_rst_in (sys_rst_in),
      .en_in      (src_en),
      .ratio_in   (per_ratio),
      .tick_out   (per_tick)
   );

   // ==========================================================
   // short chip select generation
   // ==========================================================
   wire short_ok = (csel != CS_FULL);
   wire rd_short = short_ok & csctl[SHORT_RD_BIT] & ~cyc_w;
   wire wr_short = short_ok & csctl[SHORT_WR_BIT] & cyc_w;
   // step is one fast cycle or one 32 kHz period
   wire step     = slow ? k32_tick : 1'b1;
   wire [1:0] len = slow ? 2'(SHORT_SLOW_CYC)
                         : 2'(SHORT_FAST_CYC);

   logic [1:0] rd_cnt;
   logic       rd_seen;
   logic [1:0] wr_cnt;
   logic       cs_q;

   // read: pulse starts once the second bus state is reached, so
   // wait states spent before it never stretch the pulse
   wire rd_start = rd_short & cyc & st2 & ~rd_seen;
   // pulse runs from the counter only, so it lasts exactly len steps
   wire rd_on    = (rd_cnt != 2'd0);
   // write: select while the strobe is up, through its trailing
   // edge, then the counter holds it for the rest of len steps
   wire wr_on    = (wr_short & ((cyc & wrs) | wrs_fall))
                 | (wr_cnt != 2'd0);

   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         rd_cnt     <= 2'd0;
         rd_seen    <= 1'b0;
         wr_cnt     <= 2'd0;
         cs_rd_done <= 1'b0;
         cs_wr_done <= 1'b0;
      end
      else
      begin
         cs_rd_done <= 1'b0;
         cs_wr_done <= 1'b0;
         if (!cyc)
            rd_seen <= 1'b0;
         else if (rd_start)
            rd_seen <= 1'b1;
         if (rd_start)
            rd_cnt <= len;
         else if (step && rd_cnt != 2'd0)
         begin
            rd_cnt     <= rd_cnt - 2'd1;
            cs_rd_done <= (rd_cnt == 2'd1);
         end
         // the trailing-edge cycle itself is the first hold step
         if (wr_short && wrs_fall)
            wr_cnt <= len - {1'b0, step};
         else if (step && wr_cnt != 2'd0)
         begin
            wr_cnt     <= wr_cnt - 2'd1;
            cs_wr_done <= (wr_cnt == 2'd1);
         end
      end
   end

   wire next_cs = (rd_short | wr_short) ? (rd_on | wr_on)
                                        : cyc;

   // ==========================================================
   // registered outputs
   // ==========================================================
   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         cs_q               <= 1'b0;
         cpu_clk_en_out     <= 1'b0;
         per_clk_en_out     <= 1'b0;
         osc_on_out         <= 1'b1;
         self_timed_out     <= 1'b0;
         periodic_prio_out  <= PRIO_RESET;
         periodic_force_out <= 1'b0;
         irq_out            <= 1'b0;
      end
      else
      begin
         cs_q               <= next_cs;
         cpu_clk_en_out     <= cpu_tick;
         per_clk_en_out     <= per_tick;
         osc_on_out         <= (csel != CS_32KOFF);
         self_timed_out     <= slow & csctl[SELF_TIMED_BIT];
         periodic_prio_out  <= prio;
         periodic_force_out <= force_p;
         irq_out            <= |(irq_stat & irq_mask);
      end
   end
   assign chip_sel_out = cs_q;
endmodule

// *** sim/pscs_mem_model.sv ***
// memory device model: measures each chip select pulse in clocks
// assumes an active high chip select, sampled on clock_in
`timescale 1ns/100ps
module pscs_mem_model
(
   input  wire logic       clock_in,
   input  wire logic       chip_sel_in,
   output logic [7:0]      width_out
);
   // ==========
   // pulse width
   logic [7:0] run = 8'h00;
   always_ff @(posedge clock_in)
   begin
      if (chip_sel_in)
         run <= run + 8'h01;
      else if (run != 8'h00)
      begin
         width_out <= run;
         run <= 8'h00;
      end
   end
endmodule

// *** sim/pscs_top_sva.sv ***
// checker for pscs_top: control register and control outputs
// assumes it is bound to pscs_top and sees only its ports
`timescale 1ns/100ps
module pscs_top_sva
   import pscs_pkg::*;
(
   input  wire logic       clock_in,
   input  wire logic       sys_rst_in,
   input  wire logic [3:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   input  wire logic [7:0] rdata_out,
   input  wire logic       wdog_timeout_in,
   input  wire logic       osc_on_out,
   input  wire logic       self_timed_out,
   input  wire logic [1:0] periodic_prio_out,
   input  wire logic       periodic_force_out
);
   // ==========
   // shadow of the written control fields
   wire        wr_gcs = wr_in && addr_in == ADDR_GCS;
   wire        rd_gcs = rd_in && addr_in == ADDR_GCS;
   wire        fw = wr_gcs && wdata_in[FORCE_BIT];
   logic [4:0] ctl_q;
   always_ff @(posedge clock_in)
      if (sys_rst_in)
         ctl_q <= {CSEL_RESET, PRIO_RESET};
      else if (wr_gcs)
         ctl_q <= wdata_in[CSEL_HI:PRIO_LO];
   default clocking @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   // ==========
   // relations
   sequence quiet;
      !$past(wr_gcs) && !$past(wr_gcs, 2);
   endsequence
   a_stat_legal: assert property (rdata_out[STAT_HI:STAT_LO] != 2'b10)
      else $error("status field read 10");
   a_stat_clear: assert property ((rd_gcs && !wdog_timeout_in) ##1
      (rd_gcs && !wdog_timeout_in) |=> rdata_out[STAT_HI:STAT_LO] == STAT_NONE)
      else $error("status not cleared by read");
   a_force_zero: assert property ($past(rd_gcs) |-> !rdata_out[FORCE_BIT])
      else $error("force bit read as one");
   a_force_pulse: assert property (fw |-> ##[1:2] periodic_force_out)
      else $error("force write gave no pulse");
   a_force_cause: assert property (periodic_force_out |->
      $past(fw) || $past(fw, 2))
      else $error("force pulse without force write");
   a_prio_state: assert property (quiet |-> periodic_prio_out == ctl_q[1:0])
      else $error("priority output differs from field");
   a_gcs_read: assert property ($past(rd_gcs) and quiet |->
      rdata_out[CSEL_HI:PRIO_LO] == ctl_q)
      else $error("control fields read back wrong");
   a_osc_state: assert property (quiet |->
      osc_on_out == (ctl_q[4:2] != CS_32KOFF))
      else $error("oscillator state wrong");
   a_self_timed: assert property (quiet |->
      !self_timed_out || ctl_q[4:3] == 2'b10)
      else $error("self-timed outside slow modes");
   c_force: cover property (fw ##2 1'b1);
   c_osc_off: cover property ($fell(osc_on_out));
   c_rd_twice: cover property (rd_gcs ##1 rd_gcs);
endmodule
bind pscs_top pscs_top_sva chk (.clock_in, .sys_rst_in, .addr_in, .wdata_in,
   .wr_in, .rd_in, .rdata_out, .wdog_timeout_in, .osc_on_out, .self_timed_out,
   .periodic_prio_out, .periodic_force_out);

// *** sim/pscs_top_tb.sv ***
// testbench for pscs_top: registers, interrupt and chip selects
// assumes pscs_mem_model reports the last chip select width
`timescale 1ns/100ps
module pscs_top_tb;
   import pscs_pkg::*;
   logic       clock_in = 1'b0;
   logic       sys_rst_in = 1'b1;
   logic [3:0] addr_in = 4'h0;
   logic [7:0] wdata_in = 8'h00;
   logic       wr_in = 1'b0;
   logic       rd_in = 1'b0;
   logic       wdog_timeout_in = 1'b0;
   logic       clk32k_in = 1'b0;
   logic       cycle_active_in = 1'b0;
   logic       cycle_write_in = 1'b0;
   logic       state_second_in = 1'b0;
   logic       wr_strobe_in = 1'b0;
   logic [7:0] rdata_out, cs_width;
   logic [1:0] periodic_prio_out;
   logic       chip_sel_out, cpu_clk_en_out, per_clk_en_out, osc_on_out;
   logic       self_timed_out, periodic_force_out, irq_out;
   logic [5:0] div32 = 6'h00;
   int         n_mismatch = 0;
   int         cmp_count = 0;
   pscs_top dut (.clock_in, .sys_rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
      .rdata_out, .wdog_timeout_in, .clk32k_in, .cycle_active_in,
      .cycle_write_in, .state_second_in, .wr_strobe_in, .chip_sel_out,
      .cpu_clk_en_out, .per_clk_en_out, .osc_on_out, .self_timed_out,
      .periodic_prio_out, .periodic_force_out, .irq_out);
   pscs_mem_model mem (.clock_in, .chip_sel_in(chip_sel_out),
      .width_out(cs_width));
   always #2 clock_in = ~clock_in;
   always @(posedge clock_in)
   begin
      div32 <= div32 + 6'h01;
      if (div32 == 6'h00)
         clk32k_in <= ~clk32k_in;
   end
   // ==========
   // shared tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clock_in);
      wr_in <= 1'b0;
      @(posedge clock_in);
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clock_in);
      rd_in <= 1'b0;
      #1 chk(rdata_out, e);
      @(posedge clock_in);
   endtask
   task automatic bus(input logic w, input int waits, input logic [7:0] e);
      for (int i = 0; i < waits + 6; i++)
      begin
         cycle_active_in <= 1'b1;
         cycle_write_in <= w;
         state_second_in <= (i >= waits);
         wr_strobe_in <= w && i >= waits && i < waits + 2;
         @(posedge clock_in);
      end
      cycle_active_in <= 1'b0;
      cycle_write_in <= 1'b0;
      state_second_in <= 1'b0;
      repeat (8) @(posedge clock_in);
      #1 chk(cs_width, e);
      @(posedge clock_in);
   endtask
   // ==========
   // scenarios
   task automatic t_status();
      rd_in <= 1'b1;
      addr_in <= ADDR_GCS;
      @(posedge clock_in);
      #1 chk(rdata_out, {STAT_RESET, 6'h00});
      @(posedge clock_in);
      rd_in <= 1'b0;
      #1 chk(rdata_out, 8'h00);
      @(posedge clock_in);
      wdog_timeout_in <= 1'b1;
      @(posedge clock_in);
      wdog_timeout_in <= 1'b0;
      rd_chk(ADDR_GCS, {STAT_WDOG, 6'h00});
      rd_chk(ADDR_GCS, 8'h00);
   endtask
   task automatic t_gcs();
      for (int c = 0; c < 8; c++)
      begin
         wr_reg(ADDR_GCS, {2'b11, c[0], c[2:0], c[1:0]});
         rd_chk(ADDR_GCS, {3'b000, c[2:0], c[1:0]});
         #1 chk({7'h00, osc_on_out}, {7'h00, c[2:0] != CS_32KOFF});
         chk({6'h00, periodic_prio_out}, {6'h00, c[1:0]});
         @(posedge clock_in);
      end
   endtask
   task automatic t_irq();
      wr_reg(ADDR_IRQ_STAT, 8'h0F);
      wr_reg(ADDR_IRQ_MASK, 8'h02);
      rd_chk(ADDR_IRQ_MASK, 8'h02);
      wr_reg(ADDR_GCS, 8'h20);
      repeat (3) @(posedge clock_in);
      #1 chk({7'h00, irq_out}, 8'h01);
      @(posedge clock_in);
      rd_chk(ADDR_IRQ_STAT, 8'h02);
      wr_reg(ADDR_IRQ_STAT, 8'h02);
      wr_reg(ADDR_IRQ_MASK, 8'h00);
      wr_reg(ADDR_GCS, 8'h20);
      repeat (3) @(posedge clock_in);
      #1 chk({7'h00, irq_out}, 8'h00);
      @(posedge clock_in);
      rd_chk(ADDR_IRQ_STAT, 8'h02);
      wr_reg(4'hF, 8'hFF);
      rd_chk(4'hF, 8'h00);
      rd_chk(ADDR_EVENT, 8'h00);
   endtask
   task automatic t_clk();
      int nc = 0;
      int np = 0;
      wr_reg(ADDR_GCS, {3'b000, CS_MIXED, 2'b00});
      repeat (10) @(posedge clock_in);
      repeat (24)
      begin
         @(posedge clock_in);
         #1 nc += cpu_clk_en_out;
         np += per_clk_en_out;
      end
      chk(8'(nc), 8'd3);
      chk(8'(np), 8'd24);
      wr_reg(ADDR_GCS, {3'b000, CS_DIV6, 2'b00});
      repeat (10) @(posedge clock_in);
      nc = 0;
      np = 0;
      repeat (24)
      begin
         @(posedge clock_in);
         #1 nc += cpu_clk_en_out;
         np += per_clk_en_out;
      end
      chk(8'(nc), 8'd4);
      chk(8'(np), 8'd4);
      @(posedge clock_in);
   endtask
   task automatic t_cs();
      wr_reg(ADDR_IRQ_STAT, 8'h0F);
      wr_reg(ADDR_CSCTL, 8'h00);
      bus(1'b0, 3, 8'd9);
      wr_reg(ADDR_CSCTL, 8'h03);
      for (int c = 0; c < 8; c++)
      begin
         if (c == 4 || c == 5)
            continue;
         wr_reg(ADDR_GCS, {3'b000, c[2:0], 2'b00});
         if (c == 2)
            bus(1'b0, 3, 8'd9);
         else
         begin
            bus(1'b0, c, 8'(SHORT_FAST_CYC));
            bus(1'b1, c, 8'd4);
         end
      end
      rd_chk(ADDR_IRQ_STAT, 8'h0C);
      wr_reg(ADDR_CSCTL, 8'h07);
      wr_reg(ADDR_GCS, {3'b000, CS_32K, 2'b00});
      repeat (3) @(posedge clock_in);
      #1 chk({7'h00, self_timed_out}, 8'h01);
      @(posedge clock_in);
   endtask
   task automatic print_verdict();
      $display("mismatches=%0d comparisons=%0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      #(4 * 20000);
      n_mismatch++;
      print_verdict();
   end
   initial
   begin
      repeat (20) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      t_status();
      t_gcs();
      t_irq();
      t_clk();
      t_cs();
      print_verdict();
   end
endmodule
